// File: include/pte_pkg.sv
// Shared constants and types for the pin task and event unit
package pte_pkg;
  localparam int NCH      = 8;
  localparam int NPIN     = 32;
  localparam int PSW      = 5;
  localparam int AW       = 12;
  localparam int DW       = 32;

  // Register byte offsets
  localparam logic [AW-1:0] OFS_TASK_OUT = 12'h000;
  localparam logic [AW-1:0] OFS_TASK_SET = 12'h030;
  localparam logic [AW-1:0] OFS_TASK_CLR = 12'h060;
  localparam logic [AW-1:0] OFS_EVT_IN   = 12'h100;
  localparam logic [AW-1:0] OFS_EVT_PORT = 12'h17C;
  localparam logic [AW-1:0] OFS_IEN_SET  = 12'h304;
  localparam logic [AW-1:0] OFS_IEN_CLR  = 12'h308;
  localparam logic [AW-1:0] OFS_CONFIG   = 12'h510;
  localparam logic [AW-1:0] OFS_STATUS   = 12'h600;
  localparam logic [AW-1:0] OFS_STAT_CLR = 12'h604;
  localparam logic [AW-1:0] ARRAY_SPAN   = 12'h020;

  // Channel configuration fields
  localparam int MODE_LSB = 0;
  localparam int PSEL_LSB = 8;
  localparam int POL_LSB  = 16;
  localparam int INIT_LSB = 20;

  // Port event bit in enable and status layouts
  localparam int PORT_BIT = 31;
  localparam int FLAG_BIT = 0;
  localparam int TRIG_BIT = 0;

  localparam logic [DW-1:0] RST_WORD = 32'h0000_0000;

  typedef enum logic [1:0] {
    PTE_MODE_OFF  = 2'h0,
    PTE_MODE_EVT  = 2'h1,
    PTE_MODE_TASK = 2'h3
  } pte_mode_e;

  typedef enum logic [1:0] {
    PTE_POL_NONE = 2'h0,
    PTE_POL_RISE = 2'h1,
    PTE_POL_FALL = 2'h2,
    PTE_POL_TOG  = 2'h3
  } pte_pol_e;
endpackage

// File: hdl/pte_sync.sv
// Two-stage synchroniser for a bus of pin levels
`timescale 1ns/1ps
`default_nettype none
module pte_sync #(
  parameter int W = 32
) (
  input  wire logic         clk_in,   // System clock
  input  wire logic         rst_n_in, // Async reset, active low
  input  wire logic [W-1:0] d_in,     // Asynchronous levels
  output logic      [W-1:0] q_out     // Synchronised levels
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_r <= '0;
      q_out  <= '0;
    end else begin
      meta_r <= d_in;
      q_out  <= meta_r;
    end
  end
endmodule
`default_nettype wire

// File: hdl/pte_chan.sv
// One channel: edge detection for events and output level for tasks
`timescale 1ns/1ps
`default_nettype none
module pte_chan (
  input  wire logic                     clk_in,   // System clock
  input  wire logic                     rst_n_in, // Async reset, active low
  input  wire logic [1:0]               mode_in,  // Channel mode
  input  wire logic [1:0]               pol_in,   // Polarity setting
  input  wire logic [pte_pkg::PSW-1:0]  psel_in,  // Selected pin
  input  wire logic                     init_in,  // Initial output value
  input  wire logic                     load_in,  // Config just written
  input  wire logic                     t_out_in, // Output task
  input  wire logic                     t_set_in, // Set task
  input  wire logic                     t_clr_in, // Drive low task
  input  wire logic [pte_pkg::NPIN-1:0] pins_in,  // Synchronised pins
  output logic                          evt_out,  // Edge seen, pulse
  output logic                          drv_out   // Output level
);
  logic prev_r;
  logic lvl;
  logic rise;
  logic fall;
  logic evt_mode;
  logic task_mode;

  assign lvl       = pins_in[psel_in];
  assign rise      = lvl & ~prev_r;
  assign fall      = ~lvl & prev_r;
  assign evt_mode  = (mode_in == pte_pkg::PTE_MODE_EVT);
  assign task_mode = (mode_in == pte_pkg::PTE_MODE_TASK);

  // Level of the selected pin one cycle ago
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= lvl;
    end
  end

  // edge per polarity
  // Silent while load is high: prev_r may still hold the old pin's level
  always_comb begin
    evt_out = 1'b0;
    if (evt_mode && !load_in) begin
      case (pol_in)
        pte_pkg::PTE_POL_NONE: evt_out = 1'b0;
        pte_pkg::PTE_POL_RISE: evt_out = rise;
        pte_pkg::PTE_POL_FALL: evt_out = fall;
        pte_pkg::PTE_POL_TOG:  evt_out = rise | fall;
        default:               evt_out = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      drv_out <= 1'b0;
    end else if (load_in && task_mode) begin
      drv_out <= init_in;
    end else if (task_mode) begin
      if (t_set_in) begin
        drv_out <= 1'b1;
      end else if (t_clr_in) begin
        drv_out <= 1'b0;
      end else if (t_out_in) begin
        case (pol_in)
          pte_pkg::PTE_POL_RISE: drv_out <= 1'b1;
          pte_pkg::PTE_POL_FALL: drv_out <= 1'b0;
          pte_pkg::PTE_POL_TOG:  drv_out <= ~drv_out;
          default:               drv_out <= drv_out;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// File: hdl/pte_top.sv
// Pin task and event unit: APB registers, eight channels, pin ownership
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module pte_top (
  input  wire logic                     CLK_IN,      // 10 MHz clock
  input  wire logic                     RST_N_IN,    // Async reset, low
  input  wire logic                     PSEL_IN,     // APB select
  input  wire logic                     PENABLE_IN,  // APB enable
  input  wire logic                     PWRITE_IN,   // APB write
  input  wire logic [pte_pkg::AW-1:0]   PADDR_IN,    // APB byte address
  input  wire logic [pte_pkg::DW-1:0]   PWDATA_IN,   // APB write data
  input  wire logic [3:0]               PSTRB_IN,    // APB byte strobes
  output logic      [pte_pkg::DW-1:0]   PRDATA_OUT,  // APB read data
  output logic                          PREADY_OUT,  // APB ready
  output logic                          PSLVERR_OUT, // APB error
  input  wire logic [pte_pkg::NPIN-1:0] PIN_IN,      // Pad levels
  output logic      [pte_pkg::NPIN-1:0] PIN_OUT_OUT, // Pad drive level
  output logic      [pte_pkg::NPIN-1:0] PIN_OE_OUT,  // Pad drive enable
  input  wire logic [pte_pkg::NPIN-1:0] GPIO_OUT_IN, // Port output reg
  input  wire logic [pte_pkg::NPIN-1:0] GPIO_OE_IN,  // Port direction
  input  wire logic                     SENSE_IN,    // Port sense activity
  output logic                          IRQ_OUT      // Interrupt, high
);
  localparam int NCH = pte_pkg::NCH;
  localparam int NPIN = pte_pkg::NPIN;
  localparam int PSW = pte_pkg::PSW;
  localparam int DW = pte_pkg::DW;
  localparam int AW = pte_pkg::AW;

  logic [NPIN-1:0] pins_s;
  logic [1:0]      mode_r [NCH];
  logic [1:0]      pol_r  [NCH];
  logic [PSW-1:0]  psel_r [NCH];
  logic [NCH-1:0]  init_r;
  logic [NCH-1:0]  load_r;
  logic [NCH-1:0]  evt_r;
  logic            port_r;
  logic [NCH-1:0]  ien_r;
  logic            ien_port_r;
  logic [NCH-1:0]  chev;
  logic [NCH-1:0]  drv;
  logic [NCH-1:0]  t_out;
  logic [NCH-1:0]  t_set;
  logic [NCH-1:0]  t_clr;
  logic [DW-1:0]   wmask;
  logic [DW-1:0]   wd;
  logic            wr_go;
  logic            rd_cap;
  logic            h_out;
  logic            h_set;
  logic            h_clr;
  logic            h_evt;
  logic            h_port;
  logic            h_iset;
  logic            h_iclr;
  logic            h_cfg;
  logic            h_stat;
  logic            h_sclr;
  logic            mapped;
  logic [2:0]      idx;
  logic [DW-1:0]   rdata_c;
  logic [NPIN-1:0] pin_out_nxt;
  logic [NPIN-1:0] pin_oe_nxt;

  // Address falls in an eight-word array starting at base
  function automatic logic in_arr(input logic [AW-1:0] a,
                                  input logic [AW-1:0] base);
    logic [AW-1:0] off;
    off = a - base;
    return (a >= base) && (off < pte_pkg::ARRAY_SPAN) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [2:0] arr_idx(input logic [AW-1:0] a,
                                         input logic [AW-1:0] base);
    logic [AW-1:0] off;
    off = a - base;
    return off[4:2];
  endfunction

  pte_sync #(
    .W (NPIN)
  ) u_sync (
    .clk_in   (CLK_IN),
    .rst_n_in (RST_N_IN),
    .d_in     (PIN_IN),
    .q_out    (pins_s)
  );

  // Address decode
  assign h_out  = in_arr(PADDR_IN, pte_pkg::OFS_TASK_OUT);
  assign h_set  = in_arr(PADDR_IN, pte_pkg::OFS_TASK_SET);
  assign h_clr  = in_arr(PADDR_IN, pte_pkg::OFS_TASK_CLR);
  assign h_evt  = in_arr(PADDR_IN, pte_pkg::OFS_EVT_IN);
  assign h_cfg  = in_arr(PADDR_IN, pte_pkg::OFS_CONFIG);
  assign h_port = (PADDR_IN == pte_pkg::OFS_EVT_PORT);
  assign h_iset = (PADDR_IN == pte_pkg::OFS_IEN_SET);
  assign h_iclr = (PADDR_IN == pte_pkg::OFS_IEN_CLR);
  assign h_stat = (PADDR_IN == pte_pkg::OFS_STATUS);
  assign h_sclr = (PADDR_IN == pte_pkg::OFS_STAT_CLR);
  assign mapped = h_out | h_set | h_clr | h_evt | h_cfg | h_port |
                  h_iset | h_iclr | h_stat | h_sclr;

  always_comb begin
    idx = 3'h0;
    if (h_out) begin
      idx = arr_idx(PADDR_IN, pte_pkg::OFS_TASK_OUT);
    end else if (h_set) begin
      idx = arr_idx(PADDR_IN, pte_pkg::OFS_TASK_SET);
    end else if (h_clr) begin
      idx = arr_idx(PADDR_IN, pte_pkg::OFS_TASK_CLR);
    end else if (h_evt) begin
      idx = arr_idx(PADDR_IN, pte_pkg::OFS_EVT_IN);
    end else if (h_cfg) begin
      idx = arr_idx(PADDR_IN, pte_pkg::OFS_CONFIG);
    end
  end

  // One wait state: ready rises in the second access cycle
  assign rd_cap = PSEL_IN & PENABLE_IN & ~PREADY_OUT;
  assign wr_go  = PSEL_IN & PENABLE_IN & PWRITE_IN & PREADY_OUT & mapped;

  assign wmask = {{8{PSTRB_IN[3]}}, {8{PSTRB_IN[2]}},
                  {8{PSTRB_IN[1]}}, {8{PSTRB_IN[0]}}};
  assign wd    = PWDATA_IN & wmask;

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      PREADY_OUT  <= 1'b0;
      PSLVERR_OUT <= 1'b0;
      PRDATA_OUT  <= pte_pkg::RST_WORD;
    end else begin
      PREADY_OUT  <= rd_cap;
      PSLVERR_OUT <= rd_cap & ~mapped;
      PRDATA_OUT  <= (rd_cap && !PWRITE_IN) ? rdata_c : pte_pkg::RST_WORD;
    end
  end

  // Read mux; write-only registers read as zero
  always_comb begin
    rdata_c = pte_pkg::RST_WORD;
    if (h_evt) begin
      rdata_c[pte_pkg::FLAG_BIT] = evt_r[idx];
    end else if (h_port) begin
      rdata_c[pte_pkg::FLAG_BIT] = port_r;
    end else if (h_iset || h_iclr) begin
      rdata_c[NCH-1:0]         = ien_r;
      rdata_c[pte_pkg::PORT_BIT] = ien_port_r;
    end else if (h_stat) begin
      rdata_c[NCH-1:0]         = evt_r;
      rdata_c[pte_pkg::PORT_BIT] = port_r;
    end else if (h_cfg) begin
      rdata_c[pte_pkg::MODE_LSB +: 2]   = mode_r[idx];
      rdata_c[pte_pkg::PSEL_LSB +: PSW] = psel_r[idx];
      rdata_c[pte_pkg::POL_LSB +: 2]    = pol_r[idx];
      rdata_c[pte_pkg::INIT_LSB]        = init_r[idx];
    end
  end

  // Interrupt enables
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ien_r      <= '0;
      ien_port_r <= 1'b0;
    end else if (wr_go && h_iset) begin
      ien_r      <= ien_r | wd[NCH-1:0];
      ien_port_r <= ien_port_r | wd[pte_pkg::PORT_BIT];
    end else if (wr_go && h_iclr) begin
      ien_r      <= ien_r & ~wd[NCH-1:0];
      ien_port_r <= ien_port_r & ~wd[pte_pkg::PORT_BIT];
    end
  end

  // port event flag, set wins over clear
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      port_r <= 1'b0;
    end else if (SENSE_IN) begin
      port_r <= 1'b1;
    end else if (wr_go && h_port && PSTRB_IN[0]) begin
      port_r <= PWDATA_IN[pte_pkg::FLAG_BIT];
    end else if (wr_go && h_sclr) begin
      port_r <= port_r & ~wd[pte_pkg::PORT_BIT];
    end
  end

  // Configuration registers, byte strobes honoured per field
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      for (int i = 0; i < NCH; i++) begin
        mode_r[i] <= pte_pkg::PTE_MODE_OFF;
        pol_r[i]  <= pte_pkg::PTE_POL_NONE;
        psel_r[i] <= '0;
      end
      init_r <= '0;
      load_r <= '0;
    end else begin
      load_r <= '0;
      if (wr_go && h_cfg) begin
        load_r[idx] <= 1'b1;
        if (PSTRB_IN[0]) begin
          mode_r[idx] <= PWDATA_IN[pte_pkg::MODE_LSB +: 2];
        end
        if (PSTRB_IN[1]) begin
          psel_r[idx] <= PWDATA_IN[pte_pkg::PSEL_LSB +: PSW];
        end
        if (PSTRB_IN[2]) begin
          pol_r[idx]  <= PWDATA_IN[pte_pkg::POL_LSB +: 2];
          init_r[idx] <= PWDATA_IN[pte_pkg::INIT_LSB];
        end
      end
    end
  end

  generate
    for (genvar c = 0; c < NCH; c++) begin : g_ch
      logic hit_c;
      assign hit_c    = wr_go && (idx == 3'(c)) && wd[pte_pkg::TRIG_BIT];
      assign t_out[c] = hit_c && h_out;
      assign t_set[c] = hit_c && h_set;
      assign t_clr[c] = hit_c && h_clr;

      pte_chan u_chan (
        .clk_in   (CLK_IN),
        .rst_n_in (RST_N_IN),
        .mode_in  (mode_r[c]),
        .pol_in   (pol_r[c]),
        .psel_in  (psel_r[c]),
        .init_in  (init_r[c]),
        .load_in  (load_r[c]),
        .t_out_in (t_out[c]),
        .t_set_in (t_set[c]),
        .t_clr_in (t_clr[c]),
        .pins_in  (pins_s),
        .evt_out  (chev[c]),
        .drv_out  (drv[c])
      );

      // channel event flag, hardware set wins
      always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
          evt_r[c] <= 1'b0;
        end else if (chev[c]) begin
          evt_r[c] <= 1'b1;
        end else if (wr_go && h_evt && (idx == 3'(c)) && PSTRB_IN[0]) begin
          evt_r[c] <= PWDATA_IN[pte_pkg::FLAG_BIT];
        end else if (wr_go && h_sclr && wd[c]) begin
          evt_r[c] <= 1'b0;
        end
      end
    end
  endgenerate

  // Pin ownership; lowest enabled channel wins when two select one pin
  generate
    for (genvar p = 0; p < NPIN; p++) begin : g_pin
      always_comb begin
        pin_out_nxt[p] = GPIO_OUT_IN[p];
        pin_oe_nxt[p]  = GPIO_OE_IN[p];
        for (int c = NCH - 1; c >= 0; c--) begin
          if (psel_r[c] == PSW'(p)) begin
            if (mode_r[c] == pte_pkg::PTE_MODE_TASK) begin
              pin_out_nxt[p] = drv[c];
              pin_oe_nxt[p]  = 1'b1;
            end else if (mode_r[c] == pte_pkg::PTE_MODE_EVT) begin
              pin_out_nxt[p] = 1'b0;
              pin_oe_nxt[p]  = 1'b0;
            end
            // disabled channel leaves the pin alone
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      PIN_OUT_OUT <= '0;
      PIN_OE_OUT  <= '0;
    end else begin
      PIN_OUT_OUT <= pin_out_nxt;
      PIN_OE_OUT  <= pin_oe_nxt;
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      IRQ_OUT <= 1'b0;
    end else begin
      IRQ_OUT <= (|(evt_r & ien_r)) | (port_r & ien_port_r);
    end
  end
endmodule
`default_nettype wire

// File: bench/pte_pin_env.sv
// Pad model: outside levels on every pin the unit does not drive
`timescale 1ns/1ps
`default_nettype none
module pte_pin_env (
  input  wire logic [31:0] oe_in,  // Unit drive enable
  input  wire logic [31:0] out_in, // Unit drive level
  input  wire logic [31:0] ext_in, // Outside source levels
  output logic      [31:0] pin_out // Resolved pad level
);
  // A driven pad shows the unit's level, others the outside source
  assign pin_out = (oe_in & out_in) | (~oe_in & ext_in);
endmodule
`default_nettype wire

// File: bench/pte_top_sva.sv
// Checker for bus handshake and read-back of the pin task and event unit
`timescale 1ns/1ps
`default_nettype none
module pte_top_sva (
  input wire logic        CLK_IN,     // Clock
  input wire logic        RST_N_IN,   // Reset, low
  input wire logic        PSEL_IN,    // Select
  input wire logic        PENABLE_IN, // Enable
  input wire logic        PWRITE_IN,  // Write
  input wire logic [11:0] PADDR_IN,   // Address
  input wire logic [31:0] PRDATA_OUT, // Read data
  input wire logic        PREADY_OUT, // Ready
  input wire logic        PSLVERR_OUT // Error
);
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RST_N_IN);
  logic rd_w;
  assign rd_w = PREADY_OUT && !PWRITE_IN;

  ready_wait_a: assert property ($rose(PENABLE_IN) && PSEL_IN |-> !PREADY_OUT ##1 PREADY_OUT)
    else $error("ready not in second access cycle");
  ready_pulse_a: assert property (PREADY_OUT |=> !PREADY_OUT)
    else $error("ready longer than one cycle");
  ready_xfer_a: assert property (PREADY_OUT |-> PSEL_IN && PENABLE_IN)
    else $error("ready outside access phase");
  rdata_idle_a: assert property (!PREADY_OUT |-> PRDATA_OUT == 32'h0)
    else $error("read data not zero while idle");
  err_unmapped_a: assert property (PREADY_OUT && PADDR_IN == 12'hFFC |-> PSLVERR_OUT)
    else $error("unmapped address not refused");
  ien_mapped_a: assert property (PREADY_OUT && PADDR_IN == 12'h304 |-> !PSLVERR_OUT)
    else $error("enable register refused");
  task_rd_zero_a: assert property (rd_w && PADDR_IN < 12'h090 |-> PRDATA_OUT == 32'h0)
    else $error("task register read not zero");
  ien_rsvd_a: assert property (rd_w && PADDR_IN[11:4] == 8'h30 |-> PRDATA_OUT[30:8] == 23'h0)
    else $error("enable reserved bits set");
  port_rsvd_a: assert property (rd_w && PADDR_IN == 12'h17C |-> PRDATA_OUT[31:1] == 31'h0)
    else $error("port flag reserved bits set");
  cfg_rsvd_a: assert property (rd_w && PADDR_IN[11:5] == 7'h28 |->
    (PRDATA_OUT & 32'hFFEC_E0FC) == 32'h0)
    else $error("config reserved bits set");
endmodule
bind pte_top pte_top_sva u_pte_top_sva (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN),
  .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
  .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT));
`default_nettype wire

// File: bench/tb.sv
// Self-checking bench for the pin task and event unit
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk, rst_n, psel, pen, pw, sense, rerr, prdy, perr, irq;
  logic [11:0] pa;
  logic [31:0] pwd, rdat, gout, goe, ext, prd, pout, poe, pin;
  int          errors, compares;

  pte_top u_pte_top (.CLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pw), .PADDR_IN(pa), .PWDATA_IN(pwd), .PSTRB_IN(4'hF), .PRDATA_OUT(prd),
    .PREADY_OUT(prdy), .PSLVERR_OUT(perr), .PIN_IN(pin), .PIN_OUT_OUT(pout),
    .PIN_OE_OUT(poe), .GPIO_OUT_IN(gout), .GPIO_OE_IN(goe), .SENSE_IN(sense),
    .IRQ_OUT(irq));
  pte_pin_env u_pte_pin_env (.oe_in(poe), .out_in(pout), .ext_in(ext), .pin_out(pin));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic end_of_test;
    if (errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chkb(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One bus transfer; held until ready is seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pw   <= w;
    pa   <= a;
    pwd  <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (prdy !== 1'b1) @(posedge clk);
    rdat = prd;
    rerr = perr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask

  function automatic logic [31:0] cfg(input logic [1:0] m, input logic [4:0] s,
                                      input logic [1:0] p, input logic i);
    return {11'h0, i, 2'h0, p, 3'h0, s, 6'h0, m};
  endfunction

  task automatic t_reset;
    rdc(12'h17C, 32'h0);
    rdc(12'h304, 32'h0);
    rdc(12'h308, 32'h0);
    rdc(12'h514, 32'h0);
    apb(1'b0, 12'hFFC, 32'h0);
    chkb(rerr, 1'b1);
  endtask

  task automatic t_ien;
    wr(12'h304, 32'h8000_0081);
    rdc(12'h304, 32'h8000_0081);
    rdc(12'h308, 32'h8000_0081);
    wr(12'h308, 32'h0000_0001);
    wr(12'h304, 32'h0);
    rdc(12'h304, 32'h8000_0080);
    wr(12'h308, 32'h0000_0080);
    wr(12'h304, 32'h0000_0004);
    rdc(12'h308, 32'h8000_0004);
  endtask

  task automatic pulse_sense;
    @(posedge clk);
    sense <= 1'b1;
    @(posedge clk);
    sense <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic t_sense;
    pulse_sense();
    rdc(12'h17C, 32'h1);
    chkb(irq, 1'b1);
    wr(12'h17C, 32'h0);
    repeat (2) @(posedge clk);
    chkb(irq, 1'b0);
    rdc(12'h17C, 32'h0);
    wr(12'h308, 32'h8000_0000);
    pulse_sense();
    rdc(12'h17C, 32'h1);
    chkb(irq, 1'b0);
    rdc(12'h600, 32'h8000_0000);
    wr(12'h604, 32'h8000_0000);
    rdc(12'h17C, 32'h0);
  endtask

  // Channel 1 owns pin 9 while the port register drives it high
  task automatic t_task;
    logic [3:0] outv;
    outv = 4'b0010;
    for (int p = 0; p < 4; p++) begin
      wr(12'h514, cfg(2'h3, 5'd9, p[1:0], p >= 2));
      repeat (3) @(posedge clk);
      chkb(poe[9], 1'b1);
      chkb(pin[9], p >= 2);
      wr(12'h004, 32'h1);
      repeat (3) @(posedge clk);
      chkb(pin[9], outv[p]);
    end
    rdc(12'h514, cfg(2'h3, 5'd9, 2'h3, 1'b1));
    rdc(12'h004, 32'h0);
    wr(12'h034, 32'h1);
    repeat (3) @(posedge clk);
    chkb(pin[9], 1'b1);
    wr(12'h064, 32'h1);
    repeat (3) @(posedge clk);
    chkb(pin[9], 1'b0);
    wr(12'h514, 32'h0);
    repeat (3) @(posedge clk);
    chkb(pin[9], 1'b1);
  endtask

  // Channel 2 watches pin 3; pin 4 toggles beside it
  task automatic t_event;
    logic rise, fall;
    // Selecting a high pin after a low one must not look like a rising edge
    ext[5] <= 1'b1;
    repeat (3) @(posedge clk);
    wr(12'h518, cfg(2'h1, 5'd5, 2'h1, 1'b0));
    repeat (4) @(posedge clk);
    rdc(12'h108, 32'h0);
    for (int p = 0; p < 4; p++) begin
      rise = (p == 1) || (p == 3);
      fall = (p == 2) || (p == 3);
      wr(12'h518, cfg(2'h1, 5'd3, p[1:0], 1'b1));
      repeat (4) @(posedge clk);
      chkb(poe[3], 1'b0);
      @(posedge clk);
      ext[4] <= ~ext[4];
      repeat (5) @(posedge clk);
      rdc(12'h108, 32'h0);
      ext[3] <= 1'b1;
      repeat (5) @(posedge clk);
      rdc(12'h108, {31'h0, rise});
      chkb(irq, rise);
      wr(12'h108, 32'h0);
      @(posedge clk);
      ext[3] <= 1'b0;
      repeat (5) @(posedge clk);
      rdc(12'h108, {31'h0, fall});
      wr(12'h108, 32'h0);
      repeat (2) @(posedge clk);
      chkb(irq, 1'b0);
    end
  endtask

  initial begin
    errors = 0;
    compares = 0;
    rst_n = 1'b0;
    psel = 1'b0;
    pen = 1'b0;
    pw = 1'b0;
    pa = 12'h0;
    pwd = 32'h0;
    sense = 1'b0;
    gout = 32'h0000_0A00;
    goe = 32'h0000_0F00;
    ext = 32'h0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_ien();
    t_sense();
    t_task();
    t_event();
    end_of_test();
  end

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    end_of_test();
  end
endmodule
`default_nettype wire
